// *** src/sadc_params.svh ***
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

`define SADC_WORD_BITS      16
`define SADC_CHAIN_LEN      2
`define SADC_CLK_MHZ        40

// internal conversion duration on the device clock
`define SADC_T_CONV_NS      500
`define SADC_CONV_CYCLES    ((`SADC_T_CONV_NS * `SADC_CLK_MHZ) / 1000)

// host side waits, least times, so rounded up
`define SADC_T_CONV_MAX_NS  800
`define SADC_WAIT_CYCLES    ((`SADC_T_CONV_MAX_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_T_BUSY_TMO_NS  2000
`define SADC_TMO_CYCLES     ((`SADC_T_BUSY_TMO_NS * `SADC_CLK_MHZ + 999) / 1000)

// low phase of the serial clock in host clock cycles; the high phase lasts two cycles more
`define SADC_SCLK_HALF      4

`define SADC_FIFO_DEPTH     2

`endif

// *** src/sadc_pkg.sv ***
package sadc_pkg;

  typedef enum logic [1:0] {
    SADC_D_IDLE = 2'b00,
    SADC_D_CONV = 2'b01,
    SADC_D_ACQ  = 2'b10
  } sadc_dev_st_e;

  typedef enum logic [2:0] {
    SADC_H_IDLE  = 3'b000,
    SADC_H_SETUP = 3'b001,
    SADC_H_CONV  = 3'b010,
    SADC_H_HIGH  = 3'b011,
    SADC_H_SAMP  = 3'b100,
    SADC_H_PUSH  = 3'b101,
    SADC_H_LOW   = 3'b110,
    SADC_H_ENDF  = 3'b111
  } sadc_host_st_e;

  typedef logic [15:0] sadc_word_t;

  typedef struct packed {
    sadc_dev_st_e st;
    logic [7:0]   cnt;
    sadc_word_t   sample;
    sadc_word_t   result;
    logic         busy;
    logic         pre_bit;
    logic         drive_low;
    logic         chain;
    logic         powered;
    logic         ready;
    logic         cs_m;
    logic         cs_s;
    logic         cs_p;
    logic         din_m;
    logic         din_s;
    logic         din_p;
    logic         sck_m;
    logic         sck_s;
  } sadc_dev_s;

  typedef struct packed {
    logic       edge_seen;
    sadc_word_t shreg;
  } sadc_lnk_s;

  typedef struct packed {
    sadc_host_st_e st;
    logic [7:0]    tmr;
    logic [7:0]    edges;
    logic [4:0]    bits;
    sadc_word_t    sr;
    logic          busy;
    logic          pend;
    logic          cs;
    logic          sck;
    logic          sdi_m;
    logic          sdi_s;
    logic          sdi_p;
    sadc_word_t    f0;
    sadc_word_t    f1;
    logic [1:0]    fcnt;
    logic          fvalid;
    logic          idle;
  } sadc_host_s;

endpackage : sadc_pkg

// *** src/sadc_link_if.sv ***
`timescale 1ns/1ps

interface sadc_link_if;
  logic convert_start;
  logic sclk;
  logic chain_in;
  logic chain_out;

  modport device (
    input  convert_start,
    input  sclk,
    input  chain_in,
    output chain_out
  );

  modport host (
    output convert_start,
    output sclk,
    input  chain_out
  );
endinterface : sadc_link_if

// *** src/sadc_device.sv ***
`timescale 1ns/1ps
`include "sadc_params.svh"

// Behaviour
// RULE1: serial input low at start rise selects chain
// RULE2: both inputs low drives serial output low
// RULE3: start rise samples input, begins conversion
// RULE4: host holds start high through readout
// RULE5: conversion runs on internal clock regardless
// RULE6: clock low at start means no busy
// RULE7: clock high at start gives busy indicator
// RULE8: no busy: load word, show msb
// RULE9: busy: load word, drive output high
// RULE10: falling edge captures input, shifts next bit
// RULE11: after conversion, acquire while powered down
// RULE12: last device first, each word msb first
// RULE13: host gives sixteen edges per device
// RULE14: busy adds one extra falling edge
// RULE15: bits stable across both clock edges
// RULE16: upstream busy bits are not forwarded
// RULE17: conversion time independent of serial clock
// RULE18: old result readable, power up on start
// RULE19: counter terminal count ends conversion
module sadc_device
  import sadc_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       clk_en_in,
  sadc_link_if.device                     link,
  input  wire logic [`SADC_WORD_BITS-1:0] sample_in,
  output logic                            powered_out,
  output logic                            chain_mode_out,
  output logic                            busy_mode_out,
  output logic                            result_ready_out
);

  localparam logic [7:0] CONV_LAST = 8'(`SADC_CONV_CYCLES - 1);

  sadc_dev_s r_q;
  sadc_dev_s r_d;
  sadc_lnk_s l_q;
  sadc_lnk_s l_d;
  logic      start_evt;

  // internal clock domain: synchronisers, conversion, power state
  always_comb begin
    r_d = r_q;
    start_evt = 1'h0;
    if (clk_en_in) begin
      r_d.cs_m  = link.convert_start;
      r_d.cs_s  = r_q.cs_m;
      r_d.cs_p  = r_q.cs_s;
      r_d.din_m = link.chain_in;
      r_d.din_s = r_q.din_m;
      r_d.din_p = r_q.din_s;
      r_d.sck_m = link.sclk;
      r_d.sck_s = r_q.sck_m;
      r_d.drive_low = ~r_q.cs_s & ~r_q.din_s; // RULE2
      // din_p pairs with cs_p, so a din tied to the start line still reads low
      start_evt = r_q.cs_s & ~r_q.cs_p & ~r_q.din_p; // RULE1
      unique case (r_q.st)
        SADC_D_IDLE,
        SADC_D_ACQ: begin
          // a rise with din high would pick chip-select operation, not built here
          if (start_evt) begin
            r_d.st      = SADC_D_CONV; // RULE3
            r_d.chain   = 1'h1; // RULE1
            r_d.sample  = sample_in; // RULE3
            r_d.busy    = r_q.sck_s; // RULE6 RULE7
            r_d.cnt     = 8'h00;
            r_d.pre_bit = 1'h0;
            r_d.powered = 1'h1; // RULE18
            r_d.ready   = 1'h0;
          end
        end
        SADC_D_CONV: begin
          // serial clock is never looked at here
          if (r_q.cnt == CONV_LAST) begin
            r_d.st      = SADC_D_ACQ; // RULE19 RULE17 RULE5
            r_d.result  = r_q.sample;
            r_d.pre_bit = r_q.busy ? 1'h1 : r_q.sample[`SADC_WORD_BITS-1]; // RULE8 RULE9
            r_d.powered = 1'h0; // RULE11
            r_d.ready   = 1'h1; // RULE18
          end
          else begin
            r_d.cnt = 8'(r_q.cnt + 8'h01); // RULE19
          end
        end
        // unused code: fall back to idle rather than lock up
        default: begin
          r_d.st = SADC_D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_q <= '0;
    end
    else begin
      r_q <= r_d;
    end
  end

  // link domain: shift register on serial clock falling edges.
  // result and busy are read across domains unsynchronised; they settle at
  // end of conversion and the host gives no edge until after that
  always_comb begin
    l_d = l_q;
    if (clk_en_in && r_q.ready) begin
      if (!l_q.edge_seen) begin
        l_d.edge_seen = 1'h1;
        if (r_q.busy) begin
          // upstream shows its busy bit now, so drop it
          l_d.shreg = r_q.result; // RULE16 RULE9
        end
        else begin
          l_d.shreg = {r_q.result[`SADC_WORD_BITS-2:0], link.chain_in}; // RULE10 RULE8
        end
      end
      else begin
        l_d.shreg = {l_q.shreg[`SADC_WORD_BITS-2:0], link.chain_in}; // RULE10 RULE12
      end
    end
  end

  // start low ends the frame: the link clock may stop, so the frame
  // signal itself clears this state
  always_ff @(negedge link.sclk or posedge rst_in or negedge link.convert_start) begin
    if (rst_in || !link.convert_start) begin
      l_q <= '0;
    end
    else begin
      l_q <= l_d;
    end
  end

  // bit changes only after a falling edge and holds a full period
  assign link.chain_out = r_q.drive_low ? 1'h0 : // RULE2
                          (l_q.edge_seen ? l_q.shreg[`SADC_WORD_BITS-1] : r_q.pre_bit); // RULE15 RULE12

  assign powered_out      = r_q.powered;
  assign chain_mode_out   = r_q.chain;
  assign busy_mode_out    = r_q.busy;
  assign result_ready_out = r_q.ready;

endmodule : sadc_device

// *** src/sadc_host.sv ***
`timescale 1ns/1ps
`include "sadc_params.svh"

module sadc_host
  import sadc_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       clk_en_in,
  sadc_link_if.host                       link,
  input  wire logic                       start_in,
  input  wire logic                       busy_mode_in,
  output logic                            idle_out,
  output logic [`SADC_WORD_BITS-1:0]      word_data_out,
  output logic                            word_valid_out,
  input  wire logic                       word_ready_in
);

  localparam logic [7:0] HALF_LAST = 8'(`SADC_SCLK_HALF - 1);
  localparam logic [7:0] WAIT_LAST = 8'(`SADC_WAIT_CYCLES + 4 - 1);
  localparam logic [7:0] TMO_LAST  = 8'(`SADC_TMO_CYCLES - 1);
  localparam logic [7:0] DATA_EDGS = 8'(`SADC_WORD_BITS * `SADC_CHAIN_LEN);
  localparam logic [4:0] BIT_LAST  = 5'(`SADC_WORD_BITS - 1);
  localparam logic [1:0] FIFO_FULL = 2'(`SADC_FIFO_DEPTH);

  sadc_host_s h_q;
  sadc_host_s h_d;
  logic       push;
  logic       pop;
  logic [7:0] total;

  always_comb begin
    h_d = h_q;
    push = 1'h0;
    pop = 1'h0;
    total = 8'(DATA_EDGS + {7'h00, h_q.busy}); // RULE13 RULE14
    if (clk_en_in) begin
      pop = h_q.fvalid & word_ready_in;
      h_d.sdi_m = link.chain_out;
      h_d.sdi_s = h_q.sdi_m;
      h_d.sdi_p = h_q.sdi_s;
      unique case (h_q.st)
        SADC_H_IDLE: begin
          h_d.cs  = 1'h0;
          h_d.sck = 1'h0;
          if (start_in) begin
            h_d.busy = busy_mode_in;
            h_d.sck  = busy_mode_in; // RULE6 RULE7
            h_d.tmr  = 8'h00;
            h_d.st   = SADC_H_SETUP;
          end
        end
        SADC_H_SETUP: begin
          if (h_q.tmr == HALF_LAST) begin
            h_d.cs  = 1'h1; // RULE4
            h_d.tmr = 8'h00;
            h_d.st  = SADC_H_CONV;
          end
          else begin
            h_d.tmr = 8'(h_q.tmr + 8'h01);
          end
        end
        SADC_H_CONV: begin
          h_d.tmr = 8'(h_q.tmr + 8'h01);
          // timeout keeps a missing busy edge from hanging the host
          if ((h_q.busy && h_q.sdi_s && !h_q.sdi_p) || (!h_q.busy && h_q.tmr == WAIT_LAST) ||
              h_q.tmr == TMO_LAST) begin // RULE7 RULE6
            h_d.sck   = 1'h1;
            h_d.tmr   = 8'h00;
            h_d.edges = 8'h00;
            h_d.bits  = 5'h00;
            h_d.st    = SADC_H_HIGH;
          end
        end
        SADC_H_HIGH: begin
          if (h_q.tmr == HALF_LAST) begin
            h_d.st = SADC_H_SAMP;
          end
          else begin
            h_d.tmr = 8'(h_q.tmr + 8'h01);
          end
        end
        SADC_H_SAMP: begin
          // sampled just before the falling edge
          h_d.tmr = 8'h00;
          h_d.st  = SADC_H_PUSH;
          if (!(h_q.busy && h_q.edges == 8'h00)) begin // RULE14
            h_d.sr = {h_q.sr[`SADC_WORD_BITS-2:0], h_q.sdi_s}; // RULE15 RULE12
            if (h_q.bits == BIT_LAST) begin
              h_d.bits = 5'h00;
              h_d.pend = 1'h1;
            end
            else begin
              h_d.bits = 5'(h_q.bits + 5'h01);
            end
          end
        end
        SADC_H_PUSH: begin
          // a full buffer holds the clock high, so no bit is lost
          if (!h_q.pend || h_q.fcnt != FIFO_FULL) begin
            push      = h_q.pend;
            h_d.pend  = 1'h0;
            h_d.sck   = 1'h0;
            h_d.edges = 8'(h_q.edges + 8'h01); // RULE13
            h_d.st    = SADC_H_LOW;
          end
        end
        SADC_H_LOW: begin
          if (h_q.tmr == HALF_LAST) begin
            h_d.tmr = 8'h00;
            if (h_q.edges == total) begin
              h_d.cs = 1'h0; // RULE4
              h_d.st = SADC_H_ENDF;
            end
            else begin
              h_d.sck = 1'h1;
              h_d.st  = SADC_H_HIGH;
            end
          end
          else begin
            h_d.tmr = 8'(h_q.tmr + 8'h01);
          end
        end
        SADC_H_ENDF: begin
          if (h_q.tmr == HALF_LAST) begin
            h_d.tmr = 8'h00;
            h_d.st  = SADC_H_IDLE;
          end
          else begin
            h_d.tmr = 8'(h_q.tmr + 8'h01);
          end
        end
      endcase
      case ({push, pop})
        2'b10: begin
          if (h_q.fcnt == 2'h0) begin
            h_d.f0 = h_q.sr;
          end
          else begin
            h_d.f1 = h_q.sr;
          end
          h_d.fcnt = 2'(h_q.fcnt + 2'h1);
        end
        2'b01: begin
          h_d.f0   = h_q.f1;
          h_d.fcnt = 2'(h_q.fcnt - 2'h1);
        end
        2'b11: begin
          if (h_q.fcnt == 2'h1) begin
            h_d.f0 = h_q.sr;
          end
          else begin
            h_d.f0 = h_q.f1;
            h_d.f1 = h_q.sr;
          end
        end
        2'b00: begin
        end
      endcase
      h_d.fvalid = (h_d.fcnt != 2'h0);
      h_d.idle   = (h_d.st == SADC_H_IDLE);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      h_q <= '0;
    end
    else begin
      h_q <= h_d;
    end
  end

  assign link.convert_start = h_q.cs;
  assign link.sclk          = h_q.sck;
  assign idle_out           = h_q.idle;
  assign word_data_out      = h_q.f0;
  assign word_valid_out     = h_q.fvalid;

endmodule : sadc_host

// *** test/sadc_link_monitor.sv ***
`timescale 1ns/1ps

module sadc_link_monitor (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic convert_start,
  input  wire logic sclk,
  input  wire logic chain_in,
  input  wire logic chain_out
);
  logic [5:0] falls_q;
  logic       busy_q;
  logic       sclk_q;
  logic       cs_q;

  // falling edges seen inside one frame, busy option latched at the start rise
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      falls_q <= 6'h00;
      busy_q  <= 1'b0;
      sclk_q  <= 1'b0;
      cs_q    <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cs_q   <= convert_start;
      if (!convert_start)
        falls_q <= 6'h00;
      else if (sclk_q && !sclk)
        falls_q <= falls_q + 6'h01;
      if (convert_start && !cs_q)
        busy_q <= sclk;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // device end lags its synchroniser, so allow 8 cycles
  a_drive_low: assert property ((!convert_start && !chain_in) [*8] |-> !chain_out)
    else $error("chain output not low while start and input are low");
  a_start_hold: assert property ((convert_start && falls_q < 6'h20) |=> convert_start)
    else $error("start line dropped before readout done");
  a_edge_count: assert property ($fell(convert_start) |-> falls_q == (busy_q ? 6'h21 : 6'h20))
    else $error("wrong count of falling edges in frame");
  a_busy_irq: assert property ((busy_q && convert_start && $fell(sclk) && falls_q == 6'h00) |-> $past(chain_out))
    else $error("busy indicator missing before first falling edge");
  a_irq_latency: assert property (($rose(convert_start) && sclk) |-> ##[1:80] chain_out)
    else $error("busy indicator late");
  a_bit_hold: assert property ((convert_start && sclk && $past(sclk) && falls_q != 6'h00) |-> $stable(chain_out))
    else $error("output bit changed while clock high");
  a_sclk_high: assert property (($rose(sclk) && convert_start) |-> sclk [*4])
    else $error("serial clock high phase too short");
  a_sclk_low: assert property (($fell(sclk) && convert_start) |-> !sclk [*4])
    else $error("serial clock low phase too short");

  c_busy_frame: cover property ($rose(convert_start) && sclk);
  c_plain_frame: cover property ($rose(convert_start) && !sclk);
  c_read_stall: cover property ((convert_start && sclk && falls_q != 6'h00) [*8]);
endmodule : sadc_link_monitor

// *** test/sar_adc_daisy_chain_readout_tb.sv ***
`timescale 1ns/1ps
`include "sadc_params.svh"

module sar_adc_daisy_chain_readout_tb
  import sadc_pkg::*;
;
  logic        ref_clk_in    = 1'b0;
  logic        dev_clk       = 1'b0;
  logic        rst_in        = 1'b1;
  logic        en            = 1'b1;
  logic        start_in      = 1'b0;
  logic        busy_mode_in  = 1'b0;
  logic        word_ready_in = 1'b0;
  logic        hold          = 1'b0;
  logic        idle;
  logic        valid;
  sadc_word_t  data;
  sadc_word_t  smp [2]       = '{16'h0000, 16'h0000};
  logic [1:0]  pw;
  logic [1:0]  cm;
  logic [1:0]  bm;
  logic [1:0]  rr;
  int          bad_count     = 0;
  int          cmp_count     = 0;
  int          k;
  sadc_word_t  exp_q [$];
  logic [31:0] rnd_q         = 32'h783F31E1;
  logic [31:0] rdy_q         = 32'h783F31E1;

  always #12.5 ref_clk_in = ~ref_clk_in;
  always #15 dev_clk = ~dev_clk;

  sadc_link_if link_a ();
  sadc_link_if link_b ();
  assign link_b.convert_start = link_a.convert_start;
  assign link_b.sclk          = link_a.sclk;
  assign link_b.chain_in      = link_a.convert_start;
  assign link_a.chain_in      = link_b.chain_out;

  sadc_host u_sadc_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(en), .link(link_a.host),
    .start_in(start_in), .busy_mode_in(busy_mode_in), .idle_out(idle), .word_data_out(data),
    .word_valid_out(valid), .word_ready_in(word_ready_in));
  sadc_device u_sadc_device_a (.ref_clk_in(dev_clk), .rst_in(rst_in), .clk_en_in(en), .link(link_b.device),
    .sample_in(smp[0]), .powered_out(pw[0]), .chain_mode_out(cm[0]), .busy_mode_out(bm[0]),
    .result_ready_out(rr[0]));
  sadc_device u_sadc_device_b (.ref_clk_in(dev_clk), .rst_in(rst_in), .clk_en_in(en), .link(link_a.device),
    .sample_in(smp[1]), .powered_out(pw[1]), .chain_mode_out(cm[1]), .busy_mode_out(bm[1]),
    .result_ready_out(rr[1]));
  sadc_link_monitor u_mon (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .convert_start(link_a.convert_start),
    .sclk(link_a.sclk), .chain_in(link_a.chain_in), .chain_out(link_a.chain_out));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr_next

  task automatic chk_word(input string nm, input sadc_word_t e, input sadc_word_t g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk_word(nm, {15'h0000, e}, {15'h0000, g});
  endtask : chk_flag

  task automatic stop_test;
    $display("counts: %0d mismatches in %0d comparisons", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask : tick

  task automatic wait_idle;
    for (int i = 0; i < 3000 && idle !== 1'b1; i++) tick(1);
    chk_flag("idle_out", 1'b1, idle);
  endtask : wait_idle

  // last device's word comes out first
  task automatic start_frame(input logic bsy);
    rnd_q = lfsr_next(rnd_q);
    smp[0] = rnd_q[15:0];
    smp[1] = rnd_q[31:16];
    exp_q.push_back(rnd_q[31:16]);
    exp_q.push_back(rnd_q[15:0]);
    start_in = 1'b1;
    busy_mode_in = bsy;
    tick(1);
    start_in = 1'b0;
    for (int i = 0; i < 100 && link_a.convert_start !== 1'b1; i++) tick(1);
    tick(10);
    chk_flag("powered_out", 1'b1, pw[1]);
    chk_flag("result_ready_out", 1'b0, rr[1]);
  endtask : start_frame

  task automatic end_frame(input logic bsy);
    wait_idle();
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) tick(1);
    tick(10);
    chk_word("words_left", 16'h0000, 16'(exp_q.size()));
    chk_flag("chain_out", 1'b0, link_a.chain_out);
    for (int i = 0; i < 2; i++) begin
      chk_flag("chain_mode_out", 1'b1, cm[i]);
      chk_flag("busy_mode_out", bsy, bm[i]);
      chk_flag("powered_out", 1'b0, pw[i]);
      chk_flag("result_ready_out", 1'b1, rr[i]);
    end
  endtask : end_frame

  // reader pops with random stalls
  always @(posedge ref_clk_in) begin
    if (!rst_in && valid === 1'b1 && word_ready_in === 1'b1) begin
      if (exp_q.size() == 0)
        chk_flag("word_expected", 1'b0, 1'b1);
      else
        chk_word("word_data_out", exp_q.pop_front(), data);
    end
    #2;
    rdy_q = lfsr_next(rdy_q);
    word_ready_in = hold ? 1'b0 : rdy_q[0];
  end

  initial begin
    repeat (40000) @(posedge ref_clk_in);
    bad_count++;
    stop_test();
  end

  initial begin
    tick(3);
    rst_in = 1'b0;
    for (k = 0; k < 6; k++) begin
      wait_idle();
      start_frame(k[0]);
      if (k == 2) begin
        // enable low must hold both ends mid-conversion
        en = 1'b0;
        tick(40);
        chk_flag("result_ready_out", 1'b0, rr[1]);
        chk_flag("convert_start", 1'b1, link_a.convert_start);
        en = 1'b1;
      end
      end_frame(k[0]);
    end
    // two frames unread: buffer fills, host must stall with clock high
    hold = 1'b1;
    wait_idle();
    start_frame(1'b0);
    wait_idle();
    start_frame(1'b1);
    tick(600);
    chk_flag("word_valid_out", 1'b1, valid);
    chk_flag("idle_out", 1'b0, idle);
    chk_flag("sclk", 1'b1, link_a.sclk);
    hold = 1'b0;
    end_frame(1'b1);
    // reset after the devices finish converting but before the first clock edge, then a clean frame
    wait_idle();
    start_frame(1'b0);
    tick(20);
    rst_in = 1'b1;
    tick(3);
    exp_q.delete();
    rst_in = 1'b0;
    chk_flag("convert_start", 1'b0, link_a.convert_start);
    wait_idle();
    start_frame(1'b1);
    end_frame(1'b1);
    stop_test();
  end
endmodule : sar_adc_daisy_chain_readout_tb
